//--- hdl/tpf_table_flash.sv
// Table pointer, table latch, holding registers and long write sequencer
`timescale 1ns/10ps
module tpf_table_flash
#(
  parameter int PROG_CYCLES = tpf_pkg::PROG_CYCLES
)
(
  input  wire logic                       clk_i,        // 25 MHz core clock
  input  wire logic                       sys_rst_i,    // Sync reset, high
  input  wire logic                       ce_i,         // Clock enable
  input  wire logic                       reg_wr_i,     // Register write
  input  wire logic                       reg_rd_i,     // Register read
  input  wire logic [2:0]                 reg_addr_i,   // Register index
  input  wire logic [7:0]                 reg_wdata_i,  // Write data
  output logic      [7:0]                 reg_rdata_o,  // Read data
  input  wire tpf_pkg::tpf_op_type        op_i,         // Table op request
  input  wire logic [15:0]                fl_rdata_i,   // Flash word data
  input  wire logic                       flag_clr_i,   // Clear done flag
  output tpf_pkg::tpf_flash_type          fl_o,         // Flash commands
  output logic                            busy_o,       // Op in progress
  output logic                            stall_o,      // Halt core
  output logic                            done_flag_o   // Write complete
);
  import tpf_pkg::*;

  logic [PTR_W-1:0]  ptr;
  logic [7:0]        table_latch;
  logic [7:0]        hold [HOLD_N];
  tpf_ctrl_type      ctrl;
  tpf_state_type     state;
  logic [1:0]        unlock_step;
  logic [TMR_W-1:0]  tmr;
  logic              rd_byte_sel;
  logic              long_erase;

  // Decode of the core register port
  wire wr_low    = reg_wr_i && (reg_addr_i == IDX_PTR_LOW);
  wire wr_high   = reg_wr_i && (reg_addr_i == IDX_PTR_HIGH);
  wire wr_upper  = reg_wr_i && (reg_addr_i == IDX_PTR_UPPER);
  wire wr_latch  = reg_wr_i && (reg_addr_i == IDX_LATCH);
  wire wr_ctrl   = reg_wr_i && (reg_addr_i == IDX_CONTROL);
  wire wr_unlock = reg_wr_i && (reg_addr_i == IDX_UNLOCK);

  wire op_go     = op_i.valid && (state == TPF_IDLE);
  wire idle      = (state == TPF_IDLE);

  // Pointer arithmetic stays in the low 21 bits
  // top bit kept
  wire [LOW_ADR_W-1:0] low_inc = ptr[LOW_ADR_W-1:0] + 21'h1;
  wire [LOW_ADR_W-1:0] low_dec = ptr[LOW_ADR_W-1:0] - 21'h1;
  wire [PTR_W-1:0] ptr_inc = {ptr[PTR_W-1], low_inc};
  wire [PTR_W-1:0] ptr_dec = {ptr[PTR_W-1], low_dec};

  // pre-increment uses the bumped pointer for the access
  wire [PTR_W-1:0] acc_ptr =
    (op_i.mode == TPF_PTR_PREINC) ? ptr_inc : ptr;

  logic [PTR_W-1:0] next_ptr_op;
  always_comb
  begin
    case (op_i.mode)
      TPF_PTR_KEEP:    next_ptr_op = ptr;
      TPF_PTR_POSTINC: next_ptr_op = ptr_inc;
      TPF_PTR_POSTDEC: next_ptr_op = ptr_dec;
      TPF_PTR_PREINC:  next_ptr_op = ptr_inc;
      default:         next_ptr_op = ptr;
    endcase
  end

  // three bytes form the pointer; upper keeps only 6 bits
  wire [PTR_W-1:0] next_ptr =
    wr_low   ? {ptr[PTR_W-1:8], reg_wdata_i} :
    wr_high  ? {ptr[PTR_W-1:16], reg_wdata_i, ptr[7:0]} :
    wr_upper ? {reg_wdata_i[PTR_W-17:0], ptr[15:0]} :
    op_go    ? next_ptr_op : ptr;

  // start only right after 55h, AAh with write enable
  wire start_req = wr_ctrl && reg_wdata_i[CTL_START]
                   && reg_wdata_i[CTL_WRITE_ENABLE_BIT] && (unlock_step == 2'd2)
                   && idle && !ctrl.write_start;

  // Any other register write in between loses the key pair
  wire [1:0] next_unlock =
    (wr_unlock && reg_wdata_i == UNLOCK_KEY1) ? 2'd1 :
    (wr_unlock && reg_wdata_i == UNLOCK_KEY2 && unlock_step == 2'd1)
      ? 2'd2 : 2'd0;

  // Timer width is fixed; PROG_CYCLES must stay below 2**TMR_W
  wire tmr_end = (state == TPF_LONG) && (tmr == TMR_W'(PROG_CYCLES - 1));

  // Register read mux; unlock register reads as zero
  logic [7:0] next_rdata;
  always_comb
  begin
    case (reg_addr_i)
      IDX_PTR_LOW:   next_rdata = ptr[7:0];
      IDX_PTR_HIGH:  next_rdata = ptr[15:8];
      IDX_PTR_UPPER: next_rdata = {2'b00, ptr[PTR_W-1:16]};
      IDX_LATCH:     next_rdata = table_latch;
      IDX_CONTROL:   next_rdata = {ctrl.prog_mem_select,
                                   ctrl.configuration_select, 1'b0,
                                   ctrl.erase_select, 1'b0,
                                   ctrl.write_enable_bit,
                                   ctrl.write_start, 1'b0};
      default:       next_rdata = BYTE_RST;
    endcase
  end

  // Pointer, unlock tracking and read data
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ptr         <= PTR_RST;
      unlock_step <= 2'd0;
      reg_rdata_o <= BYTE_RST;
    end
    else if (ce_i)
    begin
      ptr <= next_ptr;
      if (reg_wr_i)
        unlock_step <= next_unlock;
      if (reg_rd_i)
        reg_rdata_o <= next_rdata;
    end
  end

  // Holding bytes packed with byte 0 in the low bits
  logic [HOLD_N*8-1:0] fl_prog_bytes;

  // table write lands in the holding register by low bits
  // only a holding register changes, never the array
  genvar gi;
  generate
    for (gi = 0; gi < HOLD_N; gi++)
    begin : g_hold
      wire hit = op_go && op_i.write
                 && (acc_ptr[HOLD_IX_W-1:0] == HOLD_IX_W'(gi));
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
          hold[gi] <= BYTE_RST;
        else if (ce_i && hit)
          hold[gi] <= table_latch;
      end
      assign fl_prog_bytes[gi*8 +: 8] = hold[gi];
    end
  endgenerate

  // bit 0 picks high or low byte of the returned word
  wire [7:0] rd_byte = rd_byte_sel ? fl_rdata_i[15:8] : fl_rdata_i[7:0];

  // Table latch: a finished read overrides a register write
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      table_latch <= BYTE_RST;
    // fetched byte goes to the latch
    else if (ce_i && state == TPF_READ)
      table_latch <= rd_byte;
    else if (ce_i && wr_latch)
      table_latch <= reg_wdata_i;
  end

  // Control register bits
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl <= '0;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
      begin
        ctrl.prog_mem_select      <= reg_wdata_i[CTL_PGM_SEL];
        ctrl.configuration_select <= reg_wdata_i[CTL_CFG_SEL];
        ctrl.write_enable_bit     <= reg_wdata_i[CTL_WRITE_ENABLE_BIT];
        if (!ctrl.write_start)
          ctrl.erase_select <= reg_wdata_i[CTL_ERASE];
      end
      // software may only set the start bit
      if (start_req)
        ctrl.write_start <= 1'b1;
      else if (state == TPF_DONE)
        ctrl.write_start <= 1'b0;
      // erase select drops when the erase ends
      if (state == TPF_DONE && long_erase)
        ctrl.erase_select <= 1'b0;
    end
  end

  // Sequencer: read fetch and timed long write
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state       <= TPF_IDLE;
      tmr         <= '0;
      rd_byte_sel <= 1'b0;
      long_erase  <= 1'b0;
      fl_o        <= '0;
      busy_o      <= 1'b0;
      stall_o     <= 1'b0;
    end
    else if (ce_i)
    begin
      fl_o.rd    <= 1'b0;
      fl_o.prog  <= 1'b0;
      fl_o.erase <= 1'b0;
      case (state)
        TPF_IDLE:
        begin
          if (start_req)
          begin
            state      <= TPF_LONG;
            tmr        <= '0;
            busy_o     <= 1'b1;
            // core held for the whole timed cycle
            stall_o    <= 1'b1;
            long_erase <= reg_wdata_i[CTL_ERASE];
            fl_o.erase    <= reg_wdata_i[CTL_ERASE];
            fl_o.row_addr <= ptr[PTR_W-1:ROW_LSB];
            // all eight bytes go at once
            fl_o.prog       <= !reg_wdata_i[CTL_ERASE];
            fl_o.block_addr <= ptr[PTR_W-1:BLK_LSB];
            fl_o.prog_data  <= fl_prog_bytes;
          end
          // A read in the launch cycle is dropped; the core stalls anyway
          else if (op_go && !op_i.write)
          begin
            state <= TPF_READ;
            busy_o <= 1'b1;
            // top bit reaches the flash to pick the ID space
            // low 21 bits address main memory
            fl_o.rd        <= 1'b1;
            fl_o.word_addr <= acc_ptr[PTR_W-1:1];
            rd_byte_sel    <= acc_ptr[0];
          end
        end
        TPF_READ:
        begin
          state  <= TPF_IDLE;
          busy_o <= 1'b0;
        end
        TPF_LONG:
        begin
          tmr <= tmr + TMR_W'(1);
          if (tmr_end)
            state <= TPF_DONE;
        end
        TPF_DONE:
        begin
          state   <= TPF_IDLE;
          busy_o  <= 1'b0;
          stall_o <= 1'b0;
        end
        default:
          state <= TPF_IDLE;
      endcase
    end
  end

  // sticky flag, a new completion beats a clear
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      done_flag_o <= 1'b0;
    else if (ce_i && state == TPF_DONE)
      done_flag_o <= 1'b1;
    else if (ce_i && flag_clr_i)
      done_flag_o <= 1'b0;
  end
endmodule

//--- hdl/tpf_pkg.sv
// Constants and carrier types for the table pointer flash access block
package tpf_pkg;
  // Pointer geometry
  localparam int PTR_W     = 22;
  localparam int LOW_ADR_W = 21;
  localparam int HOLD_N    = 8;
  localparam int HOLD_IX_W = 3;
  localparam int ROW_LSB   = 6;
  localparam int BLK_LSB   = 3;
  localparam int BLK_W     = PTR_W - BLK_LSB;
  localparam int ROW_W     = PTR_W - ROW_LSB;
  localparam int WORD_W    = PTR_W - 1;

  // Register indices on the core register port
  localparam logic [2:0] IDX_PTR_LOW   = 3'h0;
  localparam logic [2:0] IDX_PTR_HIGH  = 3'h1;
  localparam logic [2:0] IDX_PTR_UPPER = 3'h2;
  localparam logic [2:0] IDX_LATCH     = 3'h3;
  localparam logic [2:0] IDX_CONTROL   = 3'h4;
  localparam logic [2:0] IDX_UNLOCK    = 3'h5;

  // Control register field positions
  localparam int CTL_PGM_SEL = 7;
  localparam int CTL_CFG_SEL = 6;
  localparam int CTL_ERASE   = 4;
  localparam int CTL_WRITE_ENABLE_BIT    = 2;
  localparam int CTL_START   = 1;

  // Unlock key bytes
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

  // Reset values
  localparam logic [PTR_W-1:0] PTR_RST   = 22'h00_0000;
  localparam logic [7:0]       BYTE_RST  = 8'h00;

  // Long write duration
  localparam int PROG_TIME_US = 2000;
  localparam int CLK_MHZ      = 25;
  localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
  localparam int TMR_W        = 17;

  typedef enum logic [1:0]
  {
    TPF_PTR_KEEP    = 2'b00,
    TPF_PTR_POSTINC = 2'b01,
    TPF_PTR_POSTDEC = 2'b10,
    TPF_PTR_PREINC  = 2'b11
  } tpf_mode_type;

  typedef enum logic [1:0]
  {
    TPF_IDLE = 2'b00,
    TPF_READ = 2'b01,
    TPF_LONG = 2'b11,
    TPF_DONE = 2'b10
  } tpf_state_type;

  typedef struct packed
  {
    logic         valid;
    logic         write;
    tpf_mode_type mode;
  } tpf_op_type;

  typedef struct packed
  {
    logic prog_mem_select;
    logic configuration_select;
    logic erase_select;
    logic write_enable_bit;
    logic write_start;
  } tpf_ctrl_type;

  typedef struct packed
  {
    logic                rd;
    logic [WORD_W-1:0]   word_addr;
    logic                prog;
    logic [BLK_W-1:0]    block_addr;
    logic [HOLD_N*8-1:0] prog_data;
    logic                erase;
    logic [ROW_W-1:0]    row_addr;
  } tpf_flash_type;
endpackage

//--- test/tpf_table_flash_chk.sv
// Assertion checker bound to the table flash access block
`timescale 1ns/10ps
module tpf_table_flash_chk
#(
  parameter int PROG_CYCLES = tpf_pkg::PROG_CYCLES
)
(
  input wire logic                   clk_i,       // Core clock
  input wire logic                   sys_rst_i,   // Sync reset
  input wire logic                   ce_i,        // Clock enable
  input wire logic                   reg_wr_i,    // Register write
  input wire tpf_pkg::tpf_op_type    op_i,        // Table op
  input wire logic                   flag_clr_i,  // Flag clear
  input wire tpf_pkg::tpf_flash_type fl_o,        // Flash commands
  input wire logic                   busy_o,      // Busy
  input wire logic                   stall_o,     // Core stall
  input wire logic                   done_flag_o  // Done flag
);
  import tpf_pkg::*;
  int stall_cnt;
  // Stall length is judged at the falling edge, not by a long repetition
  always_ff @(posedge clk_i)
    if (sys_rst_i || !stall_o)
      stall_cnt <= 0;
    else if (ce_i)
      stall_cnt <= stall_cnt + 1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_read_fetch: assert property (
    op_i.valid && !op_i.write && ce_i && !busy_o |=> fl_o.rd && busy_o)
    else $error("table read did not fetch");
  chk_write_short: assert property (
    op_i.valid && op_i.write && ce_i && !busy_o && !reg_wr_i
    |=> !busy_o && !fl_o.prog && !fl_o.erase)
    else $error("table write touched the array");
  chk_stall_busy: assert property (stall_o |-> busy_o)
    else $error("stall without busy");
  chk_stall_len: assert property ($fell(stall_o) |->
    stall_cnt >= PROG_CYCLES - 1 && stall_cnt <= PROG_CYCLES + 2)
    else $error("long write length wrong");
  chk_launch_kind: assert property (
    $rose(stall_o) |-> fl_o.prog ^ fl_o.erase)
    else $error("long write without one command");
  chk_done_set: assert property ($fell(stall_o) |-> done_flag_o)
    else $error("done flag not set at completion");
  chk_flag_sticky: assert property (
    done_flag_o && !flag_clr_i |=> done_flag_o)
    else $error("done flag dropped by itself");
  chk_stall_cause: assert property (
    !stall_o && !reg_wr_i |=> !stall_o)
    else $error("long write without register write");
  cover property (fl_o.rd);
  cover property (fl_o.prog);
  cover property (fl_o.erase);
endmodule

bind tpf_table_flash tpf_table_flash_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_u
(
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i),
  .op_i(op_i), .flag_clr_i(flag_clr_i), .fl_o(fl_o), .busy_o(busy_o),
  .stall_o(stall_o), .done_flag_o(done_flag_o)
);

//--- test/tpf_flash_model.sv
// Program flash array model answering word reads
`timescale 1ns/10ps
module tpf_flash_model
(
  input  wire logic                   clk_i,   // Core clock
  input  wire tpf_pkg::tpf_flash_type fl_i,    // Flash commands
  output logic      [15:0]            rdata_o  // Word read data
);
  import tpf_pkg::*;
  logic        rd_q = 1'b0;
  logic [15:0] word;
  assign word = {~fl_i.word_addr[7:0], fl_i.word_addr[20:13]};
  always @(posedge clk_i)
    rd_q <= fl_i.rd;
  // Data is inverted outside the read window so late sampling shows
  assign rdata_o = (fl_i.rd || rd_q) ? word : ~word;
endmodule

//--- test/tb.sv
// Self-checking bench for the table flash access block
`timescale 1ns/10ps
module tb;
  import tpf_pkg::*;
  typedef struct packed
  {
    logic [21:0]  ptr;
    tpf_mode_type mode;
    logic [21:0]  acc;
    logic [21:0]  nxt;
  } tpf_row_type;
  logic          clk_i = 1'b0;
  logic          sys_rst_i = 1'b1;
  logic          reg_wr_i = 1'b0;
  logic          reg_rd_i = 1'b0;
  logic [2:0]    reg_addr_i = 3'h0;
  logic [7:0]    reg_wdata_i = 8'h00;
  logic [7:0]    reg_rdata_o;
  tpf_op_type    op_i = '0;
  logic [15:0]   fl_rdata_i;
  logic          flag_clr_i = 1'b0;
  logic          ce_i = 1'b1;
  tpf_flash_type fl_o;
  logic          busy_o, stall_o, done_flag_o;
  int            error_cnt = 0;
  int            n_compared = 0;
  logic [7:0]    d;
  tpf_row_type   rows [5] = '{
    '{22'h00_0011, TPF_PTR_POSTINC, 22'h00_0011, 22'h00_0012},
    '{22'h1F_FFFF, TPF_PTR_POSTINC, 22'h1F_FFFF, 22'h00_0000},
    '{22'h20_0000, TPF_PTR_POSTDEC, 22'h20_0000, 22'h3F_FFFF},
    '{22'h00_0100, TPF_PTR_PREINC, 22'h00_0101, 22'h00_0101},
    '{22'h2A_BCDE, TPF_PTR_KEEP, 22'h2A_BCDE, 22'h2A_BCDE}};
  tpf_table_flash #(.PROG_CYCLES(20)) dut_u
  (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .op_i(op_i),
    .fl_rdata_i(fl_rdata_i), .flag_clr_i(flag_clr_i), .fl_o(fl_o),
    .busy_o(busy_o), .stall_o(stall_o), .done_flag_o(done_flag_o)
  );
  tpf_flash_model mem_u (.clk_i(clk_i), .fl_i(fl_o), .rdata_o(fl_rdata_i));
  initial
    forever #20 clk_i = ~clk_i;
  task automatic conclude;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  task automatic setp(input logic [21:0] p);
    wr(3'h0, p[7:0]);
    wr(3'h1, p[15:8]);
    wr(3'h2, {2'b00, p[21:16]});
  endtask
  task automatic ckp(input logic [21:0] p);
    rc(3'h0, p[7:0]);
    rc(3'h1, p[15:8]);
    rc(3'h2, {2'b00, p[21:16]});
  endtask
  task automatic op(input tpf_mode_type m, input logic w);
    @(posedge clk_i);
    op_i <= '{valid: 1'b1, write: w, mode: m};
    @(posedge clk_i);
    op_i <= '0;
    #1;
  endtask
  // Selects and enable first, then the key pair, then start
  task automatic launch(input logic [7:0] c);
    wr(3'h4, c);
    wr(3'h5, 8'h55);
    wr(3'h5, 8'hAA);
    wr(3'h4, c | 8'h02);
    #1;
  endtask
  task automatic waitdone;
    for (int i = 0; i < 200 && done_flag_o !== 1'b1; i++)
      @(posedge clk_i);
    @(posedge clk_i);
    #1;
  endtask
  initial
  begin
    repeat (3000) @(posedge clk_i);
    error_cnt++;
    $display("BAD %0t timeout", $time);
    conclude();
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    ckp(22'h00_0000);
    rc(3'h4, 8'h00);
    foreach (rows[i])
    begin
      setp(rows[i].ptr);
      op(rows[i].mode, 1'b0);
      chk(fl_o.word_addr, rows[i].acc[21:1]);
      repeat (2) @(posedge clk_i);
      rc(3'h3, rows[i].acc[0] ? ~rows[i].acc[8:1] : rows[i].acc[21:14]);
      ckp(rows[i].nxt);
    end
    wr(3'h6, 8'hFF);
    rc(3'h6, 8'h00);
    rc(3'h5, 8'h00);
    setp(22'h00_0040);
    for (int i = 0; i < 8; i++)
    begin
      wr(3'h3, 8'h10 + i[7:0]);
      op(TPF_PTR_POSTINC, 1'b1);
      chk({busy_o, fl_o.prog}, 2'b00);
    end
    setp(22'h00_0045);
    launch(8'h84);
    chk({stall_o, fl_o.prog, fl_o.block_addr}, {2'b11, 19'h0_0008});
    chk(fl_o.prog_data, 64'h1716_1514_1312_1110);
    waitdone();
    chk({stall_o, done_flag_o}, 2'b01);
    rc(3'h4, 8'h84);
    wr(3'h4, 8'h86);
    #1 chk(stall_o, 1'b0);
    launch(8'h80);
    chk(stall_o, 1'b0);
    @(posedge clk_i);
    flag_clr_i <= 1'b1;
    @(posedge clk_i);
    flag_clr_i <= 1'b0;
    #1 chk(done_flag_o, 1'b0);
    // Clock enable low must leave the pointer untouched
    ce_i <= 1'b0;
    wr(3'h0, 8'h5A);
    ce_i <= 1'b1;
    rc(3'h0, 8'h45);
    setp(22'h2A_BCFF);
    launch(8'h94);
    chk({stall_o, fl_o.erase, fl_o.row_addr}, {2'b11, 16'hAAF3});
    op(TPF_PTR_KEEP, 1'b0);
    chk(fl_o.rd, 1'b0);
    wr(3'h4, 8'h80);
    rc(3'h4, 8'h92);
    waitdone();
    rc(3'h4, 8'h80);
    chk(done_flag_o, 1'b1);
    // Mid-run reset returns pointer, control and flag to zero
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    ckp(22'h00_0000);
    rc(3'h4, 8'h00);
    chk(done_flag_o, 1'b0);
    conclude();
  end
endmodule
